// file: hw/opv_pkg.sv
// Purpose: Shared constants and types for the one-time-programmable
//          code memory program/verify port.
// Assumes: core_clk at 50 MHz on both ends.
// Notes:   Mode pin patterns are {verify_enable_pin, mode_select_b,
//          mode_select_c, mode_select_d}.
package opv_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int CODE_DEPTH = 8192;
  localparam int ENC_W = 5;
  localparam int ENC_DEPTH = 32;
  localparam logic [ADDR_W-1:0] ENC_LAST_ADDR = 13'h001f;
  localparam logic [ADDR_W-1:0] SIG_MAKER_ADDR = 13'h0030;
  localparam logic [ADDR_W-1:0] SIG_PART_ADDR = 13'h0031;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] NO_DATA_BYTE = 8'h00;
  localparam logic [4:0] PULSE_COUNT = 5'h19;

  // ----------------------------------------------------------------
  // Mode pin patterns
  // ----------------------------------------------------------------
  localparam logic [3:0] PINS_PROG_CODE = 4'hb;
  localparam logic [3:0] PINS_VERIFY = 4'h3;
  localparam logic [3:0] PINS_PROG_TABLE = 4'ha;
  localparam logic [3:0] PINS_LOCK1 = 4'hf;
  localparam logic [3:0] PINS_LOCK2 = 4'hc;
  localparam logic [3:0] PINS_SIGNATURE = 4'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int PULSE_LOW_NS = 100000;
  localparam int PULSE_HIGH_MIN_NS = 10000;
  localparam int VPP_SETUP_MIN_NS = 10000;
  localparam int READ_SETTLE_CYC = 4;
  localparam int PULSE_LOW_CYC = PULSE_LOW_NS / CLK_PERIOD_NS;
  localparam int PULSE_HIGH_CYC = (PULSE_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VPP_SETUP_CYC = (VPP_SETUP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum {
    MODE_IDLE, MODE_PROG_CODE, MODE_PROG_TABLE, MODE_LOCK1, MODE_LOCK2,
    MODE_VERIFY, MODE_SIGNATURE
  } opv_mode_type;

  typedef enum logic [2:0] {
    OP_PROG_CODE, OP_PROG_TABLE, OP_LOCK1, OP_LOCK2, OP_VERIFY, OP_SIGNATURE
  } opv_op_type;

  // Pin pattern a host must drive for an operation
  function automatic logic [3:0] opv_op_pins(input opv_op_type op);
    case (op)
      OP_PROG_CODE: opv_op_pins = PINS_PROG_CODE;
      OP_PROG_TABLE: opv_op_pins = PINS_PROG_TABLE;
      OP_LOCK1: opv_op_pins = PINS_LOCK1;
      OP_LOCK2: opv_op_pins = PINS_LOCK2;
      OP_SIGNATURE: opv_op_pins = PINS_SIGNATURE;
      default: opv_op_pins = PINS_VERIFY;
    endcase
  endfunction

endpackage

// file: hw/opv_if.sv
// Purpose: Pin-level link between the memory device and its programmer.
// Assumes: Both ends clocked by the same core_clk.
// Notes:   Data port has external pull-ups: undriven reads as all ones.
`timescale 1ns/100ps
interface opv_if;
  import opv_pkg::*;

  logic rst_pin;
  logic fetch_strobe_n;
  logic program_pulse_strobe;
  logic external_access_prog_supply;
  logic verify_enable_pin;
  logic mode_select_b;
  logic mode_select_c;
  logic mode_select_d;
  logic [7:0] addr_lo;
  logic [ADDR_W-9:0] addr_hi;
  logic [7:0] host_data_out;
  logic host_data_oe;
  logic [7:0] dev_data_out;
  logic dev_data_oe;
  logic [7:0] data_bus;

  // Pull-ups win when nobody drives
  assign data_bus = dev_data_oe ? dev_data_out :
                    host_data_oe ? host_data_out : ERASED_BYTE;

  modport dev (
    input rst_pin, fetch_strobe_n, program_pulse_strobe,
    input external_access_prog_supply, verify_enable_pin,
    input mode_select_b, mode_select_c, mode_select_d,
    input addr_lo, addr_hi, data_bus,
    output dev_data_out, dev_data_oe
  );

  modport host (
    output rst_pin, fetch_strobe_n, program_pulse_strobe,
    output external_access_prog_supply, verify_enable_pin,
    output mode_select_b, mode_select_c, mode_select_d,
    output addr_lo, addr_hi, host_data_out, host_data_oe,
    input data_bus
  );
endinterface // opv_if

// file: hw/opv_device.sv
// Purpose: Device end of the program/verify port: code memory, encryption
//          table, lock bits and verify/signature readout.
// Assumes: Link pins are synchronous to core_clk.
// Notes:   Programming only clears bits, like a real one-time array.
//
// Operation
// - Programmer keeps oscillator running during programming.
// - Programmer presents address and data byte.
// - Programmer holds program-code mode levels.
// - Twenty-five low pulses commit one byte.
// - Encryption table written at addresses 0..1F.
// - Lock bits written with their own levels.
// - Any lock blocks code and table writes.
// - Second lock bit blocks code readout.
// - Verify drives stored byte onto data port.
// - Programmed table makes readout XNOR encrypted.
// - Encryption table never readable.
// - Signature bytes at 030H and 031H.
// - Pulses low nominal width, high minimum.
// - Program-code mode pin levels.
// - Verify mode pin levels.
`timescale 1ns/100ps
module opv_device import opv_pkg::*; #(
  // Arbitrary identification values
  parameter logic [7:0] MAKER_ID = 8'h5a,
  parameter logic [7:0] PART_ID = 8'ha6
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Programmer link
  opv_if.dev link,
  // Status
  output logic [1:0] lock_bits,
  output logic table_written,
  output logic train_busy
);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  function automatic opv_mode_type decode_mode(
    input logic rst_pin,
    input logic fetch_n,
    input logic vpp,
    input logic [3:0] pins
  );
    decode_mode = MODE_IDLE;
    if (rst_pin && !fetch_n) begin
      case (pins)
        PINS_PROG_CODE: decode_mode = vpp ? MODE_PROG_CODE : MODE_IDLE;
        PINS_PROG_TABLE: decode_mode = vpp ? MODE_PROG_TABLE : MODE_IDLE;
        PINS_LOCK1: decode_mode = vpp ? MODE_LOCK1 : MODE_IDLE;
        PINS_LOCK2: decode_mode = vpp ? MODE_LOCK2 : MODE_IDLE;
        PINS_VERIFY: decode_mode = vpp ? MODE_IDLE : MODE_VERIFY;
        PINS_SIGNATURE: decode_mode = vpp ? MODE_IDLE : MODE_SIGNATURE;
        default: decode_mode = MODE_IDLE;
      endcase
    end
  endfunction

  wire logic [3:0] pins = {link.verify_enable_pin, link.mode_select_b,
                           link.mode_select_c, link.mode_select_d};
  wire logic [ADDR_W-1:0] pin_addr = {link.addr_hi, link.addr_lo};
  opv_mode_type mode;
  // enable high, b low, c/d high, supply on
  // verify needs supply off, enable low
  assign mode = decode_mode(link.rst_pin, link.fetch_strobe_n,
                            link.external_access_prog_supply, pins);
  wire logic prog_mode = (mode == MODE_PROG_CODE) || (mode == MODE_PROG_TABLE) ||
                         (mode == MODE_LOCK1) || (mode == MODE_LOCK2);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] code_mem_q [CODE_DEPTH];
  logic [7:0] enc_mem_q [ENC_DEPTH];
  logic [1:0] lock_q;
  logic enc_set_q;

  // ----------------------------------------------------------------
  // Pulse train tracking
  // ----------------------------------------------------------------
  logic strobe_prev_q;
  logic [4:0] pulse_cnt_q;
  logic [ADDR_W-1:0] addr_lat_q;
  logic [7:0] data_lat_q;
  opv_mode_type mode_lat_q;

  wire logic strobe_fall = strobe_prev_q && !link.program_pulse_strobe;
  wire logic strobe_rise = !strobe_prev_q && link.program_pulse_strobe;
  wire logic train_open = (pulse_cnt_q != 5'h00);
  // Leaving the mode mid-train discards the partial train
  wire logic train_abort = train_open && (!prog_mode || mode != mode_lat_q);
  // commit on rise ending 25th pulse
  wire logic commit = !train_abort && strobe_rise && (pulse_cnt_q == PULSE_COUNT);
  // any lock bit freezes array writes
  wire logic array_locked = |lock_q;
  wire logic in_table = (addr_lat_q <= ENC_LAST_ADDR);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strobe_prev_q <= 1'b1;
    end else begin
      strobe_prev_q <= link.program_pulse_strobe;
    end
  end

  // latch on first fall, hold for the train
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_cnt_q <= 5'h00;
      addr_lat_q <= '0;
      data_lat_q <= 8'h00;
      mode_lat_q <= MODE_IDLE;
    end else if (train_abort || commit) begin
      pulse_cnt_q <= 5'h00;
    end else if (strobe_fall && prog_mode && pulse_cnt_q != PULSE_COUNT) begin
      pulse_cnt_q <= pulse_cnt_q + 5'h01;
      if (!train_open) begin
        addr_lat_q <= pin_addr;
        data_lat_q <= link.data_bus;
        mode_lat_q <= mode;
      end
    end
  end

  // byte from data port into latched address
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < CODE_DEPTH; i++) begin
        code_mem_q[i] <= ERASED_BYTE;
      end
    end else if (commit && mode_lat_q == MODE_PROG_CODE && !array_locked) begin
      code_mem_q[addr_lat_q] <= code_mem_q[addr_lat_q] & data_lat_q;
    end
  end

  // table rows 0..1F, same pulse train
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < ENC_DEPTH; i++) begin
        enc_mem_q[i] <= ERASED_BYTE;
      end
      enc_set_q <= 1'b0;
    end else if (commit && mode_lat_q == MODE_PROG_TABLE && !array_locked && in_table) begin
      enc_mem_q[addr_lat_q[ENC_W-1:0]] <= enc_mem_q[addr_lat_q[ENC_W-1:0]] & data_lat_q;
      enc_set_q <= 1'b1;
    end
  end

  // each lock bit by its own levels
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_q <= 2'h0;
    end else if (commit) begin
      if (mode_lat_q == MODE_LOCK1) begin
        lock_q[0] <= 1'b1;
      end
      if (mode_lat_q == MODE_LOCK2) begin
        lock_q[1] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Readout
  // ----------------------------------------------------------------
  logic [7:0] dout_q;
  logic doe_q;

  wire logic [7:0] raw_byte = code_mem_q[pin_addr];
  // XNOR with table row picked by low address bits
  // table only ever leaves mixed with code
  wire logic [7:0] enc_byte = ~(raw_byte ^ enc_mem_q[pin_addr[ENC_W-1:0]]);
  wire logic [7:0] code_out = enc_set_q ? enc_byte : raw_byte;
  // identification bytes at two fixed addresses
  wire logic [7:0] sig_out = (pin_addr == SIG_MAKER_ADDR) ? MAKER_ID :
                             (pin_addr == SIG_PART_ADDR) ? PART_ID : NO_DATA_BYTE;
  wire logic verify_ok = (mode == MODE_VERIFY) && !lock_q[1];
  wire logic read_on = verify_ok || (mode == MODE_SIGNATURE);
  wire logic [7:0] dout_d = (mode == MODE_SIGNATURE) ? sig_out : code_out;

  // drive stored byte for presented address
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dout_q <= 8'h00;
      doe_q <= 1'b0;
    end else begin
      dout_q <= read_on ? dout_d : 8'h00;
      doe_q <= read_on;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.dev_data_out = dout_q;
  assign link.dev_data_oe = doe_q;
  assign lock_bits = lock_q;
  assign table_written = enc_set_q;
  assign train_busy = train_open;

endmodule // opv_device

// file: hw/opv_host.sv
// Purpose: Programmer end: turns user commands into pin sequences.
// Assumes: Device clocked by the same core_clk.
// Notes:   Idle pins sit at verify levels with the supply off.
`timescale 1ns/100ps
module opv_host import opv_pkg::*; #(
  parameter int LOW_CYC = PULSE_LOW_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Programmer link
  opv_if.host link,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire opv_op_type cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  // Response
  output logic rsp_valid,
  output logic [7:0] rsp_data
);

  typedef enum {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_HOLD, H_READ} opv_hstate_type;

  localparam logic [15:0] LOW_T = 16'(LOW_CYC - 1);
  localparam logic [15:0] HIGH_T = 16'(PULSE_HIGH_CYC - 1);
  localparam logic [15:0] SETUP_T = 16'(VPP_SETUP_CYC - 1);
  localparam logic [15:0] SETTLE_T = 16'(READ_SETTLE_CYC - 1);

  opv_hstate_type state_q;
  logic [15:0] tmr_q;
  logic [4:0] pulses_q;
  logic [3:0] pins_q;
  logic vpp_q, strobe_q, hoe_q, run_q, rsp_valid_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] data_q, rsp_data_q;

  wire logic tmr_done = (tmr_q == 16'h0000);
  wire logic is_read = (cmd_op == OP_VERIFY) || (cmd_op == OP_SIGNATURE);
  assign cmd_ready = (state_q == H_IDLE) && run_q;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= H_IDLE;
      tmr_q <= 16'h0000;
      pulses_q <= 5'h00;
      pins_q <= PINS_VERIFY;
      vpp_q <= 1'b0;
      strobe_q <= 1'b1;
      hoe_q <= 1'b0;
      run_q <= 1'b0;
      addr_q <= '0;
      data_q <= 8'h00;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 8'h00;
    end else begin
      run_q <= 1'b1;
      rsp_valid_q <= 1'b0;
      if (!tmr_done) begin
        tmr_q <= tmr_q - 16'h0001;
      end
      case (state_q)
        H_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            // address and byte onto the ports
            addr_q <= cmd_addr;
            data_q <= cmd_data;
            pins_q <= opv_op_pins(cmd_op);
            pulses_q <= 5'h00;
            vpp_q <= !is_read;
            hoe_q <= 1'b0;
            tmr_q <= is_read ? SETTLE_T : SETUP_T;
            state_q <= is_read ? H_READ : H_SETUP;
          end
        end
        // Data drive waits a cycle: device still reads out at take
        H_SETUP: begin
          hoe_q <= 1'b1;
          if (tmr_done) begin
            strobe_q <= 1'b0;
            tmr_q <= LOW_T;
            state_q <= H_LOW;
          end
        end
        // nominal low width, minimum high width
        H_LOW: begin
          if (tmr_done) begin
            strobe_q <= 1'b1;
            pulses_q <= pulses_q + 5'h01;
            tmr_q <= HIGH_T;
            state_q <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (tmr_done && pulses_q == PULSE_COUNT) begin
            tmr_q <= HIGH_T;
            state_q <= H_HOLD;
          end else if (tmr_done) begin
            strobe_q <= 1'b0;
            tmr_q <= LOW_T;
            state_q <= H_LOW;
          end
        end
        H_HOLD: begin
          if (tmr_done) begin
            vpp_q <= 1'b0;
            hoe_q <= 1'b0;
            pins_q <= PINS_VERIFY;
            rsp_valid_q <= 1'b1;
            rsp_data_q <= data_q;
            state_q <= H_IDLE;
          end
        end
        H_READ: begin
          if (tmr_done) begin
            rsp_valid_q <= 1'b1;
            rsp_data_q <= link.data_bus;
            pins_q <= PINS_VERIFY;
            state_q <= H_IDLE;
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  // reset high, fetch strobe low
  // enable low, strobe high at rest
  assign link.rst_pin = run_q;
  assign link.fetch_strobe_n = 1'b0;
  assign link.program_pulse_strobe = strobe_q;
  assign link.external_access_prog_supply = vpp_q;
  assign link.verify_enable_pin = pins_q[3];
  assign link.mode_select_b = pins_q[2];
  assign link.mode_select_c = pins_q[1];
  assign link.mode_select_d = pins_q[0];
  assign link.addr_lo = addr_q[7:0];
  assign link.addr_hi = addr_q[ADDR_W-1:8];
  assign link.host_data_out = data_q;
  assign link.host_data_oe = hoe_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;

endmodule // opv_host

// file: tb/opv_link_properties.sv
// Purpose: Concurrent checks on the pins between programmer and memory device.
// Assumes: One clock domain; both ends reset by arst_n.
// Notes:   Mode pins grouped as {verify_enable_pin, mode_select_b/c/d}.
`timescale 1ns/100ps
module opv_link_properties import opv_pkg::*; #(
  parameter int LOW_CYC = PULSE_LOW_CYC,
  // Arbitrary identification values
  parameter logic [7:0] MAKER_ID = 8'h5a,
  parameter logic [7:0] PART_ID = 8'ha6
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Mode and strobe pins
  input wire logic rst_pin,
  input wire logic fetch_strobe_n,
  input wire logic program_pulse_strobe,
  input wire logic external_access_prog_supply,
  input wire logic verify_enable_pin,
  input wire logic mode_select_b,
  input wire logic mode_select_c,
  input wire logic mode_select_d,
  // Address and data
  input wire logic [7:0] addr_lo,
  input wire logic [ADDR_W-9:0] addr_hi,
  input wire logic host_data_oe,
  input wire logic [7:0] dev_data_out,
  input wire logic dev_data_oe
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic [15:0] low_q, high_q;
  logic [4:0] fall_q;
  logic strobe_q;
  wire logic [3:0] pins = {verify_enable_pin, mode_select_b, mode_select_c, mode_select_d};
  wire logic base_ok = rst_pin && !fetch_strobe_n && !external_access_prog_supply;
  wire logic read_mode = base_ok && (pins == PINS_VERIFY || pins == PINS_SIGNATURE);
  wire logic sig_mode = base_ok && pins == PINS_SIGNATURE;
  wire logic [ADDR_W-1:0] addr = {addr_hi, addr_lo};
  wire logic [7:0] sig_exp = (addr == SIG_MAKER_ADDR) ? MAKER_ID :
                             (addr == SIG_PART_ADDR) ? PART_ID : NO_DATA_BYTE;

  // High count saturates so long idle stretches never wrap
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_q <= 16'h0000;
      high_q <= 16'h0000;
      fall_q <= 5'h00;
      strobe_q <= 1'b1;
    end else begin
      strobe_q <= program_pulse_strobe;
      low_q <= program_pulse_strobe ? 16'h0000 : low_q + 16'h0001;
      high_q <= !program_pulse_strobe ? 16'h0000 : high_q + {15'h0000, high_q != 16'hffff};
      fall_q <= !external_access_prog_supply ? 5'h00 :
                fall_q + {4'h0, strobe_q && !program_pulse_strobe};
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  low_width_a: assert property ($rose(program_pulse_strobe) |-> low_q == 16'(LOW_CYC))
    else $error("strobe low width off");
  high_width_a: assert property ($fell(program_pulse_strobe) |-> high_q >= 16'(PULSE_HIGH_CYC))
    else $error("strobe high time too short");
  prog_levels_a: assert property ($fell(program_pulse_strobe) |-> rst_pin && !fetch_strobe_n
    && external_access_prog_supply && verify_enable_pin) else $error("pulse outside program levels");
  pulse_count_a: assert property ($fell(external_access_prog_supply) |-> fall_q == PULSE_COUNT)
    else $error("train pulse count wrong");
  train_hold_a: assert property (external_access_prog_supply && fall_q != 5'h00
    |-> $stable({pins, addr})) else $error("mode or address moved in train");
  drive_cause_a: assert property (dev_data_oe |-> $past(read_mode))
    else $error("device drove data outside readout");
  no_clash_a: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive data port");
  sig_value_a: assert property (sig_mode |=> dev_data_oe && dev_data_out == $past(sig_exp))
    else $error("identification byte wrong");

  train_done_c: cover property ($fell(external_access_prog_supply));
  verify_drive_c: cover property (dev_data_oe && pins == PINS_VERIFY);
  sig_drive_c: cover property (dev_data_oe && pins == PINS_SIGNATURE);
endmodule // opv_link_properties

// file: tb/testbench.sv
// Purpose: Both link ends joined; host commands checked against a byte model.
// Assumes: Short strobe low width in simulation.
// Notes:   Five program trains dominate the run time.
`timescale 1ns/100ps
module testbench;
  import opv_pkg::*;
  localparam int LOW_SIM = 20;
  // Arbitrary identification values
  localparam logic [7:0] MAKER_SIM = 8'h3c;
  localparam logic [7:0] PART_SIM = 8'hc3;
  logic core_clk, arst_n, cmd_valid, cmd_ready, rsp_valid, table_written, train_busy;
  logic [1:0] lock_bits;
  opv_op_type cmd_op;
  logic [ADDR_W-1:0] cmd_addr, a_code;
  logic [7:0] cmd_data, rsp_data, d_code, d_tbl;
  int err_total = 0;
  int check_count = 0;
  int cyc_count = 0;
  int mem_m [CODE_DEPTH];
  int tbl_m [ENC_DEPTH];
  int lock1_m, lock2_m, tw_m;

  opv_if link();
  opv_device #(.MAKER_ID(MAKER_SIM), .PART_ID(PART_SIM)) i_opv_device (.core_clk(core_clk),
    .arst_n(arst_n), .link(link), .lock_bits(lock_bits), .table_written(table_written),
    .train_busy(train_busy));
  opv_host #(.LOW_CYC(LOW_SIM)) i_opv_host (.core_clk(core_clk), .arst_n(arst_n), .link(link),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  opv_link_properties #(.LOW_CYC(LOW_SIM), .MAKER_ID(MAKER_SIM), .PART_ID(PART_SIM))
  i_opv_link_properties (.core_clk(core_clk), .arst_n(arst_n), .rst_pin(link.rst_pin),
    .fetch_strobe_n(link.fetch_strobe_n), .program_pulse_strobe(link.program_pulse_strobe),
    .external_access_prog_supply(link.external_access_prog_supply),
    .verify_enable_pin(link.verify_enable_pin), .mode_select_b(link.mode_select_b),
    .mode_select_c(link.mode_select_c), .mode_select_d(link.mode_select_d),
    .addr_lo(link.addr_lo), .addr_hi(link.addr_hi), .host_data_oe(link.host_data_oe),
    .dev_data_out(link.dev_data_out), .dev_data_oe(link.dev_data_oe));

  // clock never stops during the run
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Five trains of about 14000 cycles each
  always @(posedge core_clk) begin
    cyc_count++;
    if (cyc_count == 80000) begin
      err_total++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Checking and model
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [7:0] model_read(input opv_op_type op, input logic [ADDR_W-1:0] a);
    int v;
    if (op == OP_SIGNATURE) v = (a == SIG_MAKER_ADDR) ? MAKER_SIM : (a == SIG_PART_ADDR) ? PART_SIM : 0;
    else if (lock2_m != 0) v = 255;
    else if (tw_m != 0) v = 255 - (mem_m[a] ^ tbl_m[a[4:0]]);
    else v = mem_m[a];
    return v[7:0];
  endfunction

  // Cells only lose ones; any lock freezes code and table
  task automatic model_prog(input opv_op_type op, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int locked;
    locked = lock1_m | lock2_m;
    case (op)
      OP_PROG_CODE: if (locked == 0) mem_m[a] = mem_m[a] & d;
      OP_PROG_TABLE: if (locked == 0 && a <= ENC_LAST_ADDR) begin
        tbl_m[a[4:0]] = tbl_m[a[4:0]] & d;
        tw_m = 1;
      end
      OP_LOCK1: lock1_m = 1;
      OP_LOCK2: lock2_m = 1;
      default: ;
    endcase
  endtask

  task automatic run_cmd(input opv_op_type op, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [7:0] exp;
    int n;
    exp = (op == OP_VERIFY || op == OP_SIGNATURE) ? model_read(op, a) : d;
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      @(negedge core_clk);
      n++;
    end
    chk("rsp_valid", {7'h00, rsp_valid}, 8'h01);
    chk("rsp_data", rsp_data, exp);
    if (op != OP_VERIFY && op != OP_SIGNATURE) model_prog(op, a, d);
    chk("lock_bits", {6'h00, lock_bits}, {6'h00, lock2_m[0], lock1_m[0]});
    chk("table_written", {7'h00, table_written}, {7'h00, tw_m[0]});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_VERIFY;
    cmd_addr = '0;
    cmd_data = 8'h00;
    lock1_m = 0;
    lock2_m = 0;
    tw_m = 0;
    foreach (mem_m[i]) mem_m[i] = 255;
    foreach (tbl_m[i]) tbl_m[i] = 255;
    void'($urandom(86));
    a_code = {8'($urandom_range(255, 2)), 5'h1f};
    d_code = 8'($urandom);
    d_tbl = 8'($urandom);
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    arst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    run_cmd(OP_VERIFY, a_code, 8'h00);
    run_cmd(OP_VERIFY, 13'h0000, 8'h00);
    for (int k = 0; k < 3; k++) run_cmd(OP_SIGNATURE, SIG_MAKER_ADDR + 13'(k), 8'h00);
    run_cmd(OP_PROG_CODE, a_code, d_code);
    run_cmd(OP_VERIFY, a_code, 8'h00);
    run_cmd(OP_PROG_TABLE, ENC_LAST_ADDR, d_tbl);
    run_cmd(OP_VERIFY, a_code, 8'h00);
    // first lock, then a refused write
    run_cmd(OP_LOCK1, a_code, 8'h00);
    run_cmd(OP_PROG_CODE, a_code, 8'h00);
    run_cmd(OP_VERIFY, a_code, 8'h00);
    run_cmd(OP_LOCK2, a_code, 8'h00);
    run_cmd(OP_VERIFY, a_code, 8'h00);
    run_cmd(OP_SIGNATURE, SIG_PART_ADDR, 8'h00);
    chk("train_busy", {7'h00, train_busy}, 8'h00);
    stop_test();
  end
endmodule // testbench
